//--- pdm_cfg.svh
// constants for the program and data memory map block
// Operation
// - program store holds 1K words of 14 bits, addressed by program counter
// - any reset loads program counter with 000H and fetching starts there
// - table data is addressed by its own table pointer register
// - table read puts low byte in named location, upper bits in table-high
// - unused table-high bits read back as zero after a table read
// - current-page table read treats pointer as offset into current page
// - table-high is read-only; only table reads update it
// - every table instruction takes two instruction cycles
// - programming link: one two-way data line plus programmer-driven clock
// - programming data and clock share port A bits 0 and 2
// - data memory is 8 bits wide and starts at address 00H
// - special registers read in both banks; MP0, MP1, bank select and TBLP written in bank 0 only; eeprom control at 40H bank 1 only
// - data bank of indirect access through MP1 follows the bank select register
// - 64 bytes general purpose memory in bank 0 at 40H to 7FH
// - bit set and bit clear change one bit only
// - reads of unused special addresses return 00H
// - protected special registers ignore software writes
// - program page is 256 words; low byte writes stay in page
// - bank select bit 0 chooses bank 0 or bank 1
// - direct addressing always reaches bank 0; bank 1 only indirectly
`ifndef PDM_CFG_SVH
`define PDM_CFG_SVH
`define PDM_PROG_WORDS 1024
`define PDM_PROG_WIDTH 14
`define PDM_PC_RESET 10'h000
`define PDM_LAST_PAGE 2'h3
`define PDM_ADDR_INDIRECT_ACCESS_0 8'h00
`define PDM_ADDR_MP0 8'h01
`define PDM_ADDR_INDIRECT_ACCESS_1 8'h02
`define PDM_ADDR_MP1 8'h03
`define PDM_ADDR_BANK 8'h04
`define PDM_ADDR_PCL 8'h06
`define PDM_ADDR_TBLP 8'h07
`define PDM_ADDR_TABLE_HIGH_BYTE 8'h08
`define PDM_ADDR_EEC 8'h40
`define PDM_GP_BASE 8'h40
`define PDM_GP_LAST 8'h7f
`define PDM_SFR_LAST 8'h3f
`define PDM_BANK_BIT 0
`define PDM_REG_RESET 8'h00
`define PDM_TABLE_HIGH_BYTE_PAD 2'h0
`define PDM_CYC_DIV 2'h3
`define PDM_ICP_ADDR_END 5'h0a
`define PDM_ICP_FRAME_END 5'h18
`endif

//--- pdm_pkg.sv
// types for the program and data memory map block
package pdm_pkg;
   typedef enum logic [0:0] {
      PDM_TAB_IDLE = 1'b0,
      PDM_TAB_WAIT = 1'b1
   } pdm_tab_state_t;
   typedef enum logic [1:0] {
      PDM_ICP_CMD = 2'b00,
      PDM_ICP_WDATA = 2'b01,
      PDM_ICP_RDATA = 2'b10
   } pdm_icp_state_t;
endpackage

//--- pdm_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module pdm_sync #(
   parameter int W = 1
) (
   input wire logic clock_in,
   input wire logic reset_n_in,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] meta;
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         meta <= '0;
         sync_out <= '0;
      end else begin
         meta <= async_in;
         sync_out <= meta;
      end
   end
endmodule

//--- pdm_memory_map.sv
// program flash, banked data memory, table read path and programming link
`timescale 1ns/1ps
`include "pdm_cfg.svh"
module pdm_memory_map #(
   parameter int PROG_WORDS = `PDM_PROG_WORDS,
   parameter int GP_BYTES = 64
) (
   input wire logic clock_in,
   input wire logic reset_n_in,
   output logic cyc_en_out,
   output logic [9:0] pc_out,
   output logic [13:0] instr_out,
   input wire logic pc_inc_in,
   input wire logic jump_in,
   input wire logic [9:0] jump_addr_in,
   input wire logic [7:0] dm_addr_in,
   input wire logic dm_wr_in,
   input wire logic [7:0] dm_wdata_in,
   input wire logic bit_set_in,
   input wire logic bit_clr_in,
   input wire logic [2:0] bit_sel_in,
   output logic [7:0] dm_rdata_out,
   input wire logic tab_rd_in,
   input wire logic tab_last_in,
   input wire logic [7:0] tab_dest_in,
   output logic tab_busy_out,
   output logic ext_sel_out,
   output logic ext_wr_out,
   output logic [7:0] ext_addr_out,
   output logic [7:0] ext_wdata_out,
   input wire logic [7:0] ext_rdata_in,
   input wire logic prog_mode_in,
   input wire logic pa0_drive_in,
   input wire logic pa0_oe_n_in,
   input wire logic pa2_drive_in,
   input wire logic pa2_oe_n_in,
   input wire logic pa0_pin_in,
   input wire logic pa2_pin_in,
   output logic pa0_pin_out,
   output logic pa0_pin_oe_n_out,
   output logic pa2_pin_out,
   output logic pa2_pin_oe_n_out,
   output logic [1:0] pa_pin_sync_out
);
   import pdm_pkg::*;

   logic [13:0] flash [0:PROG_WORDS-1];
   logic [7:0] gp_ram [0:GP_BYTES-1];
   logic [1:0] div, next_div;
   logic [9:0] pc, next_pc;
   logic [7:0] mp0, next_mp0, mp1, next_mp1, bank, next_bank;
   logic [7:0] tblp, next_tblp, tbl_high, next_tbl_high;
   logic [7:0] rdata, next_rdata;
   logic [13:0] instr, next_instr;
   pdm_tab_state_t tab_st, next_tab_st;
   logic [9:0] tab_addr, next_tab_addr;
   logic [7:0] tab_dest, next_tab_dest;
   logic cyc_en, tab_go, tab_done, core_op;
   logic [7:0] acc_addr, ea, rv, wval;
   logic ea_bank, indirect, we, ram_hit, unused_hit, ext_hit;
   logic [13:0] tab_word;

   assign cyc_en = (div == `PDM_CYC_DIV);
   assign tab_go = cyc_en && tab_st == PDM_TAB_IDLE && tab_rd_in;
   assign tab_done = cyc_en && tab_st == PDM_TAB_WAIT;
   assign core_op = cyc_en && tab_st == PDM_TAB_IDLE && !tab_rd_in;
   assign tab_word = flash[tab_addr];

   // resolve effective address and bank
   always_comb begin
      acc_addr = tab_done ? tab_dest : dm_addr_in;
      indirect = 1'b0;
      ea = acc_addr;
      ea_bank = 1'b0;
      if (acc_addr == `PDM_ADDR_INDIRECT_ACCESS_0) begin
         indirect = 1'b1;
         ea = mp0;
      end else if (acc_addr == `PDM_ADDR_INDIRECT_ACCESS_1) begin
         indirect = 1'b1;
         ea = mp1;
         ea_bank = bank[`PDM_BANK_BIT];
      end
   end

   // decode of the resolved location
   always_comb begin
      ram_hit = 1'b0;
      ext_hit = 1'b0;
      unused_hit = 1'b0;
      rv = 8'h00;
      if (indirect && (ea == `PDM_ADDR_INDIRECT_ACCESS_0 || ea == `PDM_ADDR_INDIRECT_ACCESS_1)) begin
         rv = 8'h00;
      end else if (ea <= `PDM_SFR_LAST) begin
         if (ea == `PDM_ADDR_MP0) begin
            rv = mp0;
         end else if (ea == `PDM_ADDR_MP1) begin
            rv = mp1;
         end else if (ea == `PDM_ADDR_BANK) begin
            rv = bank;
         end else if (ea == `PDM_ADDR_PCL) begin
            rv = pc[7:0];
         end else if (ea == `PDM_ADDR_TBLP) begin
            rv = tblp;
         end else if (ea == `PDM_ADDR_TABLE_HIGH_BYTE) begin
            rv = tbl_high;
         end else if (ea == 8'h09 || ea == 8'h0c || ea == 8'h10 || ea == 8'h13 || ea == 8'h1a || ea == 8'h1d
                      || ea == 8'h2e || ea >= 8'h3a) begin
            unused_hit = 1'b1;
         end else begin
            ext_hit = 1'b1;
            rv = ext_rdata_in;
         end
      end else if (!ea_bank && ea <= `PDM_GP_LAST) begin
         ram_hit = 1'b1;
         rv = gp_ram[ea[5:0]];
      end else if (ea_bank && ea == `PDM_ADDR_EEC) begin
         ext_hit = 1'b1;
         rv = ext_rdata_in;
      end else begin
         unused_hit = 1'b1;
      end
   end

   // write value, with single-bit modify
   always_comb begin
      wval = dm_wdata_in;
      if (tab_done) begin
         wval = tab_word[7:0];
      end else if (bit_set_in) begin
         wval = rv | (8'h01 << bit_sel_in);
      end else if (bit_clr_in) begin
         wval = rv & ~(8'h01 << bit_sel_in);
      end
      we = tab_done || (core_op && (dm_wr_in || bit_set_in || bit_clr_in));
   end

   assign ext_sel_out = ext_hit && (we || cyc_en);
   assign ext_wr_out = ext_hit && we;
   assign ext_addr_out = ea;
   assign ext_wdata_out = wval;

   always_comb begin
      next_div = div + 2'h1;
      next_pc = pc;
      next_mp0 = mp0;
      next_mp1 = mp1;
      next_bank = bank;
      next_tblp = tblp;
      next_tbl_high = tbl_high;
      next_tab_st = tab_st;
      next_tab_addr = tab_addr;
      next_tab_dest = tab_dest;
      next_rdata = rv;
      next_instr = flash[pc];
      if (we && !indirect && acc_addr == `PDM_ADDR_PCL) begin
         next_pc = {pc[9:8], wval};
      end else if (core_op && jump_in) begin
         next_pc = jump_addr_in;
      end else if (cyc_en && pc_inc_in) begin
         next_pc = pc + 10'h001;
      end
      if (we && !ea_bank) begin
         if (ea == `PDM_ADDR_MP0) next_mp0 = wval;
         if (ea == `PDM_ADDR_MP1) next_mp1 = wval;
         if (ea == `PDM_ADDR_BANK) next_bank = {7'h00, wval[`PDM_BANK_BIT]};
         if (ea == `PDM_ADDR_TBLP) next_tblp = wval;
      end
      if (tab_go) begin
         next_tab_st = PDM_TAB_WAIT;
         next_tab_dest = tab_dest_in;
         if (tab_last_in) begin
            next_tab_addr = {`PDM_LAST_PAGE, tblp};
         end else begin
            next_tab_addr = {pc[9:8], tblp};
         end
      end else if (tab_done) begin
         next_tab_st = PDM_TAB_IDLE;
         next_tbl_high = {`PDM_TABLE_HIGH_BYTE_PAD, tab_word[13:8]};
      end
   end

   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         div <= 2'h0;
         pc <= `PDM_PC_RESET;
         mp0 <= `PDM_REG_RESET;
         mp1 <= `PDM_REG_RESET;
         bank <= `PDM_REG_RESET;
         tblp <= `PDM_REG_RESET;
         tbl_high <= `PDM_REG_RESET;
         tab_st <= PDM_TAB_IDLE;
         tab_addr <= 10'h000;
         tab_dest <= 8'h00;
         rdata <= 8'h00;
         instr <= 14'h0000;
      end else begin
         div <= next_div;
         pc <= next_pc;
         mp0 <= next_mp0;
         mp1 <= next_mp1;
         bank <= next_bank;
         tblp <= next_tblp;
         tbl_high <= next_tbl_high;
         tab_st <= next_tab_st;
         tab_addr <= next_tab_addr;
         tab_dest <= next_tab_dest;
         rdata <= next_rdata;
         instr <= next_instr;
      end
   end

   always_ff @(posedge clock_in) begin
      if (we && ram_hit) gp_ram[ea[5:0]] <= wval;
   end

   assign cyc_en_out = cyc_en;
   assign pc_out = pc;
   assign instr_out = instr;
   assign dm_rdata_out = rdata;
   assign tab_busy_out = (tab_st == PDM_TAB_WAIT);

   // programming link: frame of rw bit, 10 address bits, 14 data bits
   logic [1:0] pin_s;
   logic ck_d;
   pdm_icp_state_t icp_st, next_icp_st;
   logic [4:0] icp_cnt, next_icp_cnt;
   logic [10:0] icp_cmd, next_icp_cmd;
   logic [13:0] icp_data, next_icp_data;
   logic icp_drive, next_icp_drive, icp_we, ck_rise, next_ck_d;

   pdm_sync #(.W(2)) u_pin_sync (
      .clock_in(clock_in),
      .reset_n_in(reset_n_in),
      .async_in({pa2_pin_in, pa0_pin_in}),
      .sync_out(pin_s)
   );
   assign ck_rise = pin_s[1] && !ck_d;

   always_comb begin
      next_ck_d = pin_s[1];
      next_icp_st = icp_st;
      next_icp_cnt = icp_cnt;
      next_icp_cmd = icp_cmd;
      next_icp_data = icp_data;
      next_icp_drive = icp_drive;
      icp_we = 1'b0;
      if (!prog_mode_in) begin
         next_icp_st = PDM_ICP_CMD;
         next_icp_cnt = 5'h00;
         next_icp_drive = 1'b0;
      end else if (ck_rise) begin
         next_icp_cnt = icp_cnt + 5'h01;
         case (icp_st)
            PDM_ICP_CMD: begin
               next_icp_cmd = {icp_cmd[9:0], pin_s[0]};
               if (icp_cnt == `PDM_ICP_ADDR_END) begin
                  if (icp_cmd[9]) begin
                     next_icp_st = PDM_ICP_RDATA;
                     next_icp_data = flash[{icp_cmd[8:0], pin_s[0]}];
                     next_icp_drive = 1'b1;
                  end else begin
                     next_icp_st = PDM_ICP_WDATA;
                  end
               end
            end
            PDM_ICP_WDATA: begin
               next_icp_data = {icp_data[12:0], pin_s[0]};
               if (icp_cnt == `PDM_ICP_FRAME_END) begin
                  icp_we = 1'b1;
                  next_icp_st = PDM_ICP_CMD;
                  next_icp_cnt = 5'h00;
               end
            end
            PDM_ICP_RDATA: begin
               next_icp_data = {icp_data[12:0], 1'b0};
               if (icp_cnt == `PDM_ICP_FRAME_END) begin
                  next_icp_st = PDM_ICP_CMD;
                  next_icp_cnt = 5'h00;
                  next_icp_drive = 1'b0;
               end
            end
            default: next_icp_st = PDM_ICP_CMD;
         endcase
      end
   end

   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         ck_d <= 1'b0;
         icp_st <= PDM_ICP_CMD;
         icp_cnt <= 5'h00;
         icp_cmd <= 11'h000;
         icp_data <= 14'h0000;
         icp_drive <= 1'b0;
      end else begin
         ck_d <= next_ck_d;
         icp_st <= next_icp_st;
         icp_cnt <= next_icp_cnt;
         icp_cmd <= next_icp_cmd;
         icp_data <= next_icp_data;
         icp_drive <= next_icp_drive;
      end
   end

   always_ff @(posedge clock_in) begin
      if (icp_we) flash[icp_cmd[9:0]] <= {icp_data[12:0], pin_s[0]};
   end

   // pins shared with port A bits 0 and 2
   always_comb begin
      if (prog_mode_in) begin
         pa0_pin_out = icp_data[13];
         pa0_pin_oe_n_out = !icp_drive;
         pa2_pin_out = 1'b0;
         pa2_pin_oe_n_out = 1'b1;
      end else begin
         pa0_pin_out = pa0_drive_in;
         pa0_pin_oe_n_out = pa0_oe_n_in;
         pa2_pin_out = pa2_drive_in;
         pa2_pin_oe_n_out = pa2_oe_n_in;
      end
   end
   assign pa_pin_sync_out = pin_s;

   sequence s_tab_wait;
      tab_busy_out [*4];
   endsequence
   property p_tab_two;
      @(posedge clock_in) disable iff (!reset_n_in) tab_go |=> s_tab_wait ##0 tab_done;
   endproperty
   a_tab_two: assert property (p_tab_two) else $error("table read not two cycles");
   property p_table_high_byte_pad;
      @(posedge clock_in) disable iff (!reset_n_in) tab_done |=> tbl_high[7:6] == 2'h0;
   endproperty
   a_table_high_byte_pad: assert property (p_table_high_byte_pad) else $error("table high pad not zero");
   property p_table_high_byte_ro;
      @(posedge clock_in) disable iff (!reset_n_in) !tab_done |=> $stable(tbl_high);
   endproperty
   a_table_high_byte_ro: assert property (p_table_high_byte_ro) else $error("table high changed without table read");
   property p_tab_high;
      @(posedge clock_in) disable iff (!reset_n_in) tab_done |=> tbl_high[5:0] == $past(tab_word[13:8]);
   endproperty
   a_tab_high: assert property (p_tab_high) else $error("table high wrong");
   property p_last_page;
      @(posedge clock_in) disable iff (!reset_n_in) tab_go && tab_last_in |=> tab_addr == {2'h3, $past(tblp)};
   endproperty
   a_last_page: assert property (p_last_page) else $error("last page address wrong");
   property p_cur_page;
      @(posedge clock_in) disable iff (!reset_n_in)
         tab_go && !tab_last_in |=> tab_addr[9:8] == $past(pc[9:8]) && tab_addr[7:0] == $past(tblp);
   endproperty
   a_cur_page: assert property (p_cur_page) else $error("current page address wrong");
   property p_pcl_page;
      @(posedge clock_in) disable iff (!reset_n_in)
         we && !indirect && acc_addr == 8'h06 |=> pc == {$past(pc[9:8]), $past(wval)};
   endproperty
   a_pcl_page: assert property (p_pcl_page) else $error("pcl write left page");
   property p_unused_zero;
      @(posedge clock_in) disable iff (!reset_n_in) unused_hit |=> dm_rdata_out == 8'h00;
   endproperty
   a_unused_zero: assert property (p_unused_zero) else $error("unused address read nonzero");
   property p_direct_bank0;
      @(posedge clock_in) disable iff (!reset_n_in) !indirect |-> !ea_bank;
   endproperty
   a_direct_bank0: assert property (p_direct_bank0) else $error("direct access left bank 0");
   property p_pc_reset;
      @(posedge clock_in) $rose(reset_n_in) |-> pc == 10'h000;
   endproperty
   a_pc_reset: assert property (p_pc_reset) else $error("pc not zero after reset");
endmodule

//--- pdm_sfr_model.sv
// model of the external special registers behind the block
`timescale 1ns/1ps
module pdm_sfr_model (
   input wire logic clock_in,
   input wire logic cyc_en_in,
   input wire logic sel_in,
   input wire logic wr_in,
   input wire logic [7:0] addr_in,
   input wire logic [7:0] wdata_in,
   output logic [7:0] rdata_out
);
   logic [7:0] regs [256];
   logic [7:0] last;
   initial begin
      for (int i = 0; i < 256; i++)
         regs[i] = 8'h5a ^ i[7:0];
      last = 8'h00;
   end
   always @(posedge clock_in) begin
      if (sel_in && wr_in && cyc_en_in)
         regs[addr_in] <= wdata_in;
      if (sel_in)
         last <= regs[addr_in];
   end
   // unselected bus shows no stale value
   assign rdata_out = sel_in ? regs[addr_in] : ~last;
endmodule

//--- pdm_memory_map_tb.sv
// self-checking bench for the memory map block
`timescale 1ns/1ps
module pdm_memory_map_tb;
   logic clock_in, reset_n_in, pc_inc_in, jump_in, dm_wr_in, bit_set_in, bit_clr_in, tab_rd_in, tab_last_in;
   logic prog_mode_in, pa0_drive_in, pa0_oe_n_in, pa2_drive_in, pa2_oe_n_in, tb_pa0, pa2_pin_in;
   logic cyc_en_out, tab_busy_out, ext_sel_out, ext_wr_out, pa0_pin_out, pa0_pin_oe_n_out, pa2_pin_out, pa2_pin_oe_n_out;
   logic [9:0] jump_addr_in, pc_out;
   logic [13:0] instr_out, w0, w1;
   logic [7:0] dm_addr_in, dm_wdata_in, tab_dest_in, ext_rdata_in, dm_rdata_out, ext_addr_out, ext_wdata_out, v, g;
   logic [2:0] bit_sel_in;
   logic [1:0] pa_pin_sync_out;
   logic [31:0] seed;
   wire logic pa0_pin_in;
   int bad_count, checks, n;
   logic [7:0] rl [6] = '{8'h01, 8'h03, 8'h04, 8'h06, 8'h07, 8'h08};
   logic [7:0] ul [9] = '{8'h09, 8'h0c, 8'h10, 8'h13, 8'h1a, 8'h1d, 8'h2e, 8'h3a, 8'h3f};

   // device wins the data line while it drives
   assign pa0_pin_in = pa0_pin_oe_n_out ? tb_pa0 : pa0_pin_out;

   pdm_memory_map DUT (.clock_in, .reset_n_in, .cyc_en_out, .pc_out, .instr_out, .pc_inc_in, .jump_in,
      .jump_addr_in, .dm_addr_in, .dm_wr_in, .dm_wdata_in, .bit_set_in, .bit_clr_in, .bit_sel_in, .dm_rdata_out,
      .tab_rd_in, .tab_last_in, .tab_dest_in, .tab_busy_out, .ext_sel_out, .ext_wr_out, .ext_addr_out,
      .ext_wdata_out, .ext_rdata_in, .prog_mode_in, .pa0_drive_in, .pa0_oe_n_in, .pa2_drive_in, .pa2_oe_n_in,
      .pa0_pin_in, .pa2_pin_in, .pa0_pin_out, .pa0_pin_oe_n_out, .pa2_pin_out, .pa2_pin_oe_n_out, .pa_pin_sync_out);
   pdm_sfr_model SFR (.clock_in, .cyc_en_in(cyc_en_out), .sel_in(ext_sel_out), .wr_in(ext_wr_out),
      .addr_in(ext_addr_out), .wdata_in(ext_wdata_out), .rdata_out(ext_rdata_in));

   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task give_verdict;
      $display("checks %0d errors %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // ends on the edge that takes the request
   task automatic take;
      int k;
      k = 0;
      do begin
         @(negedge clock_in);
         k++;
      end while (!(cyc_en_out === 1'b1 && tab_busy_out === 1'b0) && k < 20);
      @(posedge clock_in);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock_in);
      dm_addr_in <= a;
      dm_wdata_in <= d;
      dm_wr_in <= 1'b1;
      take;
      dm_wr_in <= 1'b0;
   endtask
   // external registers answer only while selected, at the cycle strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock_in);
      dm_addr_in <= a;
      take;
      @(negedge clock_in);
      d = dm_rdata_out;
   endtask
   task automatic bop(input logic [7:0] a, input logic [2:0] b, input logic s);
      @(posedge clock_in);
      dm_addr_in <= a;
      bit_sel_in <= b;
      bit_set_in <= s;
      bit_clr_in <= !s;
      take;
      bit_set_in <= 1'b0;
      bit_clr_in <= 1'b0;
   endtask
   task automatic tab(input logic last, input logic [7:0] dst, input logic [13:0] w);
      logic [7:0] d;
      @(posedge clock_in);
      tab_rd_in <= 1'b1;
      tab_last_in <= last;
      tab_dest_in <= dst;
      take;
      tab_rd_in <= 1'b0;
      n = 0;
      repeat (8) begin
         @(negedge clock_in);
         if (tab_busy_out === 1'b1)
            n++;
      end
      chk("busy clocks", 16'd4, n[15:0]);
      rd(dst, d);
      chk("table low", {8'h00, w[7:0]}, {8'h00, d});
      rd(8'h08, d);
      chk("table high", {10'h000, w[13:8]}, {8'h00, d});
   endtask
   task automatic icp_bit(input logic b);
      @(posedge clock_in);
      tb_pa0 <= b;
      pa2_pin_in <= 1'b0;
      repeat (4) @(posedge clock_in);
      pa2_pin_in <= 1'b1;
      repeat (4) @(posedge clock_in);
   endtask
   task automatic icp_wr(input logic [9:0] a, input logic [13:0] d);
      logic [24:0] f;
      f = {1'b0, a, d};
      for (int i = 24; i >= 0; i--)
         icp_bit(f[i]);
      repeat (8) @(posedge clock_in);
   endtask
   task automatic icp_rd(input logic [9:0] a, input logic [13:0] d);
      for (int i = 10; i >= 0; i--)
         icp_bit(i == 10 ? 1'b1 : a[i]);
      for (int i = 13; i >= 0; i--) begin
         chk("icp read bit", {15'h0000, d[i]}, {14'h0000, pa0_pin_oe_n_out, pa0_pin_out});
         icp_bit(1'b0);
      end
      chk("icp release", 16'h0001, {15'h0000, pa0_pin_oe_n_out});
   endtask

   initial begin
      clock_in = 1'b0;
      forever #10 clock_in = ~clock_in;
   end
   initial begin
      #1000000;
      bad_count++;
      give_verdict;
   end
   initial begin
      {reset_n_in, pc_inc_in, jump_in, dm_wr_in, bit_set_in, bit_clr_in, tab_rd_in, tab_last_in} = '0;
      {prog_mode_in, pa0_drive_in, pa2_drive_in, tb_pa0, pa2_pin_in, pa0_oe_n_in, pa2_oe_n_in} = 7'h03;
      {jump_addr_in, dm_addr_in, dm_wdata_in, tab_dest_in, bit_sel_in} = '0;
      bad_count = 0;
      checks = 0;
      seed = 32'd12062;
      repeat (10) @(posedge clock_in);
      reset_n_in <= 1'b1;
      @(negedge clock_in);
      chk("pc at reset", 16'h0000, {6'h00, pc_out});
      foreach (rl[i]) begin
         rd(rl[i], v);
         chk("register at reset", 16'h0000, {8'h00, v});
      end
      for (int i = 0; i < 4; i++) begin
         @(posedge clock_in);
         seed = xs(seed);
         {pa0_drive_in, pa0_oe_n_in, pa2_drive_in, pa2_oe_n_in} <= seed[3:0];
         @(negedge clock_in);
         chk("port pins", {pa0_drive_in, pa0_oe_n_in, pa2_drive_in, pa2_oe_n_in},
            {pa0_pin_out, pa0_pin_oe_n_out, pa2_pin_out, pa2_pin_oe_n_out});
      end
      @(posedge clock_in);
      prog_mode_in <= 1'b1;
      @(negedge clock_in);
      chk("icp data idle", 16'h0001, {15'h0000, pa0_pin_oe_n_out});
      seed = xs(seed);
      w0 = seed[13:0];
      seed = xs(seed);
      w1 = seed[13:0];
      icp_wr(10'h122, w0);
      icp_wr(10'h322, w1);
      chk("pin sync", {14'h0000, pa2_pin_in, pa0_pin_in}, {14'h0000, pa_pin_sync_out});
      icp_rd(10'h122, w0);
      @(posedge clock_in);
      prog_mode_in <= 1'b0;
      foreach (ul[i]) begin
         seed = xs(seed);
         wr(ul[i], seed[7:0]);
         rd(ul[i], v);
         chk("unused read", 16'h0000, {8'h00, v});
      end
      wr(8'h08, 8'hff);
      rd(8'h08, v);
      chk("table high write", 16'h0000, {8'h00, v});
      for (int i = 0; i < 8; i++) begin
         seed = xs(seed);
         g = i == 0 ? 8'h40 : i == 1 ? 8'h7f : {2'b01, seed[13:8]};
         wr(g, seed[7:0]);
         rd(g, v);
         chk("general memory", {8'h00, seed[7:0]}, {8'h00, v});
         bop(g, seed[18:16], 1'b1);
         bop(g, seed[21:19], 1'b0);
         rd(g, v);
         chk("bit ops", {8'h00, (seed[7:0] | (8'h01 << seed[18:16])) & ~(8'h01 << seed[21:19])}, {8'h00, v});
      end
      seed = xs(seed);
      wr(8'h04, 8'hff);
      rd(8'h04, v);
      chk("bank select", 16'h0001, {8'h00, v});
      wr(8'h03, 8'h40);
      wr(8'h02, seed[7:0]);
      @(negedge clock_in);
      chk("bank 1 eeprom ctl", {8'h00, seed[7:0]}, {8'h00, SFR.regs[8'h40]});
      wr(8'h40, seed[15:8]);
      rd(8'h40, v);
      chk("direct stays bank 0", {8'h00, seed[15:8]}, {8'h00, v});
      rd(8'h02, v);
      chk("indirect bank 1", {8'h00, seed[7:0]}, {8'h00, v});
      wr(8'h04, 8'h00);
      rd(8'h02, v);
      chk("indirect bank 0", {8'h00, seed[15:8]}, {8'h00, v});
      wr(8'h01, 8'h45);
      wr(8'h00, seed[23:16]);
      rd(8'h45, v);
      chk("pointer 0", {8'h00, seed[23:16]}, {8'h00, v});
      wr(8'h0a, seed[31:24]);
      rd(8'h0a, v);
      chk("external register", {8'h00, seed[31:24]}, {8'h00, v});
      @(posedge clock_in);
      jump_addr_in <= 10'h110;
      jump_in <= 1'b1;
      take;
      jump_in <= 1'b0;
      wr(8'h06, 8'h22);
      @(negedge clock_in);
      chk("pc low write", 16'h0122, {6'h00, pc_out});
      repeat (2) @(negedge clock_in);
      chk("fetch word", {2'b00, w0}, {2'b00, instr_out});
      wr(8'h07, 8'h22);
      tab(1'b0, 8'h42, w0);
      tab(1'b1, 8'h43, w1);
      @(posedge clock_in);
      pc_inc_in <= 1'b1;
      take;
      pc_inc_in <= 1'b0;
      @(negedge clock_in);
      chk("pc step", 16'h0123, {6'h00, pc_out});
      give_verdict;
   end
endmodule
